//--- logic/ssr_pkg.sv
// Package for the soft starter ramp and overload controller.
// Assumes a 200 MHz system clock and a plain register port with 16-bit data.
package ssr_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 10_000_000; // Control tick, 10 ms
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_SEC = 1_000_000_000 / TICK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Register offsets (word index on the register port)
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_FLC = 5'h00;
  localparam logic [4:0] OFS_SF = 5'h01;
  localparam logic [4:0] OFS_OL_START = 5'h02;
  localparam logic [4:0] OFS_OL_RUN = 5'h03;
  localparam logic [4:0] OFS_OL_MODE = 5'h04;
  localparam logic [4:0] OFS_PROFILE = 5'h05;
  localparam logic [4:0] OFS_R1_BASE = 5'h06; // +0 init V, +1 init I, +2 time, +3 limit
  localparam logic [4:0] OFS_R2_BASE = 5'h0A;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_RAMP_REF = 5'h11;

  // ---------------------------------------------------------------
  // Status field positions
  // ---------------------------------------------------------------
  localparam int ST_STATE_LSB = 0; // 3 bits
  localparam int ST_TRIP_BIT = 3;
  localparam int ST_RAMP2_BIT = 4;
  localparam int ST_CURTYPE_BIT = 5;
  localparam int ST_CLAMP_BIT = 6;
  localparam int ST_UNPROG_BIT = 7;

  // ---------------------------------------------------------------
  // Reset values and legal ranges (percent, seconds, class)
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_FLC = 16'h0000; // Unprogrammed
  localparam logic [15:0] RST_SF = 16'h0064; // 1.00 in hundredths
  localparam logic [15:0] RST_OL_CLASS = 16'h000A;
  localparam logic [15:0] RST_OL_MODE = 16'h0000;
  localparam logic [15:0] RST_PROFILE = 16'h0001;
  localparam logic [15:0] RST_INIT_V = 16'h003C;
  localparam logic [15:0] RST_INIT_I = 16'h00C8;
  localparam logic [15:0] RST_TIME = 16'h000A;
  localparam logic [15:0] RST_LIMIT = 16'h015E;
  localparam logic [15:0] FLC_MIN = 16'h0032;
  localparam logic [15:0] SF_MIN = 16'h0064;
  localparam logic [15:0] SF_MAX = 16'h0082;
  localparam logic [15:0] SF_FLC_SUM = 16'h00C8; // FLC max = 200 - SF
  localparam logic [31:0] UNIT_MAX_PROD = 32'h0000_2710; // 100% x 1.00
  localparam logic [15:0] CLASS_MIN = 16'h0005;
  localparam logic [15:0] CLASS_MAX = 16'h001E;
  localparam logic [15:0] MODE_MAX = 16'h0002;
  localparam logic [15:0] PROF_MIN = 16'h0001;
  localparam logic [15:0] PROF_MAX = 16'h0004;
  localparam logic [15:0] VOLT_MAX = 16'h0064;
  localparam logic [15:0] CUR_MAX = 16'h0258;
  localparam logic [15:0] TIME_MIN = 16'h0001;
  localparam logic [15:0] TIME_MAX = 16'h0078;
  localparam logic [15:0] LIMIT_MIN = 16'h00C8;
  localparam logic [15:0] FULL_VOLT = 16'h0064;

  typedef enum logic [1:0] {
    OLM_MANUAL = 2'b00,
    OLM_AUTO = 2'b01,
    OLM_OFF = 2'b10
  } ssr_olm_t;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_RAMP = 3'b010,
    ST_RUN = 3'b011,
    ST_TRIP = 3'b100
  } ssr_state_t;

  // One ramp's settings travel together
  typedef struct packed {
    logic [15:0] init_v;
    logic [15:0] init_i;
    logic [15:0] time_s;
    logic [15:0] limit;
  } ssr_ramp_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } ssr_req_t;
endpackage : ssr_pkg

//--- logic/ssr_ctrl.sv
// Soft starter ramp profile, current clamp and overload policy controller.
// Assumes all inputs are synchronous to clk_sys; the thermal model, the
// full-speed detector and the non-volatile trip memory sit outside.
//
// Function
// - Profile selector 1-4 sets both ramp types
// - Ramp two only with dual-ramp input closed
// - Ramp one voltage start for profile 1/3
// - Ramp one current start for profile 2/4
// - Ramp two voltage start for profile 1/4
// - Ramp two current start for profile 2/3
// - Ramp time 1-120 s, default 10
// - Clamp current to limit until speed/trip; the code also releases it when the ramp time runs out
// - Current percentages relative to motor FULL_LOAD_AMPS
// - Full-speed detection may end ramp early
// - Service factor 1.00-1.30, refuse over-rating
// - Start overload class 5-30, default 10
// - Run class only after full speed; the code also switches to it when the ramp time runs out
// - Manual reset needs cooling plus reset key
// - Automatic reset after cooling, two-wire immediate
// - Mode 2 never trips on thermal overload
// - Power cycle keeps trip; auto clears when cool
// - No motor operation while FULL_LOAD_AMPS unprogrammed
// - FULL_LOAD_AMPS 50-100%, bound lowered by service factor
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module ssr_ctrl
  import ssr_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire ssr_req_t reg_req,
  output logic [15:0] reg_rdata,
  // Operator and feedback inputs
  input wire logic start_cmd,
  input wire logic two_wire_mode,
  input wire logic reset_key,
  input wire logic dual_ramp_in,
  input wire logic at_full_speed,
  input wire logic [15:0] motor_current,
  input wire logic thermal_over,
  input wire logic cool_done,
  input wire logic trip_retained,
  // Output stage and thermal model
  output logic drive_en,
  output logic ramp_is_current,
  output logic [15:0] ramp_ref,
  output logic [15:0] current_limit,
  output logic [31:0] current_limit_abs,
  output logic current_clamp,
  output logic [15:0] ol_class,
  output logic ol_tripped
);

  // ---------------------------------------------------------------
  // Settings registers
  // ---------------------------------------------------------------
  logic [15:0] flc_q, sf_q, ol_start_q, ol_run_q, mode_q, prof_q;
  ssr_ramp_t r1_q, r2_q;
  logic [15:0] wd;
  logic [4:0] wa;
  logic [31:0] sf_prod;
  assign wd = reg_req.wdata;
  assign wa = reg_req.addr;
  assign sf_prod = flc_q * wd;

  // Validated writes; out-of-range values are dropped and the old value kept
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flc_q <= RST_FLC;
      sf_q <= RST_SF;
      ol_start_q <= RST_OL_CLASS;
      ol_run_q <= RST_OL_CLASS;
      mode_q <= RST_OL_MODE;
      prof_q <= RST_PROFILE;
      r1_q <= {RST_INIT_V, RST_INIT_I, RST_TIME, RST_LIMIT};
      r2_q <= {RST_INIT_V, RST_INIT_I, RST_TIME, RST_LIMIT};
    end else if (reg_req.wr) begin
      case (wa)
        OFS_FLC: begin
          if (wd >= FLC_MIN && wd <= SF_FLC_SUM - sf_q) flc_q <= wd;
        end
        OFS_SF: begin
          if (wd >= SF_MIN && wd <= SF_MAX && sf_prod <= UNIT_MAX_PROD) sf_q <= wd;
        end
        OFS_OL_START: begin
          if (wd >= CLASS_MIN && wd <= CLASS_MAX) ol_start_q <= wd;
        end
        OFS_OL_RUN: begin
          if (wd >= CLASS_MIN && wd <= CLASS_MAX) ol_run_q <= wd;
        end
        OFS_OL_MODE: begin
          if (wd <= MODE_MAX) mode_q <= wd;
        end
        OFS_PROFILE: begin
          if (wd >= PROF_MIN && wd <= PROF_MAX) prof_q <= wd;
        end
        OFS_R1_BASE: begin
          if (wd <= VOLT_MAX) r1_q.init_v <= wd;
        end
        OFS_R1_BASE + 5'h01: begin
          if (wd <= CUR_MAX) r1_q.init_i <= wd;
        end
        OFS_R1_BASE + 5'h02: begin
          if (wd >= TIME_MIN && wd <= TIME_MAX) r1_q.time_s <= wd;
        end
        OFS_R1_BASE + 5'h03: begin
          if (wd >= LIMIT_MIN && wd <= CUR_MAX) r1_q.limit <= wd;
        end
        OFS_R2_BASE: begin
          if (wd <= VOLT_MAX) r2_q.init_v <= wd;
        end
        OFS_R2_BASE + 5'h01: begin
          if (wd <= CUR_MAX) r2_q.init_i <= wd;
        end
        OFS_R2_BASE + 5'h02: begin
          if (wd >= TIME_MIN && wd <= TIME_MAX) r2_q.time_s <= wd;
        end
        OFS_R2_BASE + 5'h03: begin
          if (wd >= LIMIT_MIN && wd <= CUR_MAX) r2_q.limit <= wd;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Profile decode and ramp selection
  // ---------------------------------------------------------------
  logic r1_cur, r2_cur, sel_r2, act_cur;
  ssr_ramp_t act;
  logic [15:0] init_lvl, target, start_lvl, delta;
  logic [31:0] n_ticks;

  // Type per ramp: 1 V/V, 2 I/I, 3 V/I, 4 I/V
  assign r1_cur = (prof_q == 16'h0002) || (prof_q == 16'h0004);
  assign r2_cur = (prof_q == 16'h0002) || (prof_q == 16'h0003);

  // Dual-ramp input picks the settings at the start; open means ramp one only
  logic act_r2_q;
  ssr_state_t state_q;
  // While idle the input is followed live, so the start level loaded on the
  // start edge already comes from the ramp that the same edge latches
  assign sel_r2 = (state_q == ST_IDLE) ? dual_ramp_in : act_r2_q;
  assign act = sel_r2 ? r2_q : r1_q;
  assign act_cur = sel_r2 ? r2_cur : r1_cur;

  // Only the initial level matching the ramp type is used
  assign init_lvl = act_cur ? act.init_i : act.init_v;
  // Voltage ramps end at full voltage, current ramps at the limit (% of FULL_LOAD_AMPS)
  assign target = act_cur ? act.limit : FULL_VOLT;
  assign start_lvl = (init_lvl > target) ? target : init_lvl;
  assign delta = target - start_lvl;
  assign n_ticks = act.time_s * TICKS_PER_SEC;

  // ---------------------------------------------------------------
  // Control tick
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 32'(TICK_LEN - 1));

  // Free-running divider; ramps start at any phase of it, so the first
  // step may come up to one tick early
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic start_d1_q, go, ramp_done, trip_now, reset_ok;
  logic [15:0] ref_q;
  logic [31:0] acc_q, el_q;
  logic unprog;

  assign unprog = (flc_q == RST_FLC);
  // Two-wire control runs on the level, three-wire on a fresh press
  assign go = two_wire_mode ? start_cmd : (start_cmd && !start_d1_q);
  assign ramp_done = at_full_speed || ((el_q >= n_ticks) && (ref_q == target));
  assign trip_now = thermal_over && (mode_q != 16'(OLM_OFF));
  // Manual needs key and cooling; automatic only cooling
  assign reset_ok = cool_done && ((mode_q == 16'(OLM_AUTO)) || reset_key);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_d1_q <= 1'b0;
    end else begin
      start_d1_q <= start_cmd;
    end
  end

  // State machine; the retained trip is reloaded after each power-up
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_INIT;
    end else begin
      case (state_q)
        ST_INIT: begin
          state_q <= trip_retained ? ST_TRIP : ST_IDLE;
        end
        ST_IDLE: begin
          if (go && !unprog) state_q <= ST_RAMP;
        end
        ST_RAMP: begin
          if (trip_now) state_q <= ST_TRIP;
          else if (!start_cmd) state_q <= ST_IDLE;
          else if (ramp_done) state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (trip_now) state_q <= ST_TRIP;
          else if (!start_cmd) state_q <= ST_IDLE;
        end
        ST_TRIP: begin
          if (reset_ok) state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_INIT;
        end
      endcase
    end
  end

  // Ramp selection latched at start so a mid-ramp change cannot jump
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      act_r2_q <= 1'b0;
    end else if (state_q == ST_IDLE && go) begin
      act_r2_q <= dual_ramp_in;
    end
  end

  // Linear reference: each tick adds the span to an accumulator, and each
  // whole step of n_ticks is paid out one count per clock, well inside a tick
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ref_q <= 16'h0000;
      acc_q <= 32'h0000_0000;
      el_q <= 32'h0000_0000;
    end else if (state_q != ST_RAMP) begin
      ref_q <= (state_q == ST_RUN) ? target : start_lvl;
      acc_q <= 32'h0000_0000;
      el_q <= 32'h0000_0000;
    end else if (tick && el_q < n_ticks) begin
      acc_q <= acc_q + {16'h0000, delta};
      el_q <= el_q + 32'h0000_0001;
    end else if (acc_q >= n_ticks && ref_q < target) begin
      acc_q <= acc_q - n_ticks;
      ref_q <= ref_q + 16'h0001;
    end else if (tick) begin
      el_q <= el_q;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic in_motion;
  assign in_motion = (state_q == ST_RAMP) || (state_q == ST_RUN);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      drive_en <= 1'b0;
      ramp_is_current <= 1'b0;
      ramp_ref <= 16'h0000;
      current_limit <= RST_LIMIT;
      current_limit_abs <= 32'h0000_0000;
      current_clamp <= 1'b0;
      ol_class <= RST_OL_CLASS;
      ol_tripped <= 1'b0;
    end else begin
      drive_en <= in_motion && !unprog;
      ramp_is_current <= act_cur;
      ramp_ref <= ref_q;
      current_limit <= act.limit;
      // Limit scaled by FULL_LOAD_AMPS: units of 1/10000 of unit maximum
      current_limit_abs <= act.limit * flc_q;
      // Clamp only while motor current is at or above the limit during the ramp, released when the ramp ends or on trip
      current_clamp <= (state_q == ST_RAMP) && !trip_now
                       && (motor_current >= act.limit);
      // Starting class until the ramp ends at full speed or at the ramp time, then the running class
      ol_class <= (state_q == ST_RUN) ? ol_run_q : ol_start_q;
      ol_tripped <= (state_q == ST_TRIP);
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.rd) begin
      case (wa)
        OFS_FLC: reg_rdata <= flc_q;
        OFS_SF: reg_rdata <= sf_q;
        OFS_OL_START: reg_rdata <= ol_start_q;
        OFS_OL_RUN: reg_rdata <= ol_run_q;
        OFS_OL_MODE: reg_rdata <= mode_q;
        OFS_PROFILE: reg_rdata <= prof_q;
        OFS_R1_BASE: reg_rdata <= r1_q.init_v;
        OFS_R1_BASE + 5'h01: reg_rdata <= r1_q.init_i;
        OFS_R1_BASE + 5'h02: reg_rdata <= r1_q.time_s;
        OFS_R1_BASE + 5'h03: reg_rdata <= r1_q.limit;
        OFS_R2_BASE: reg_rdata <= r2_q.init_v;
        OFS_R2_BASE + 5'h01: reg_rdata <= r2_q.init_i;
        OFS_R2_BASE + 5'h02: reg_rdata <= r2_q.time_s;
        OFS_R2_BASE + 5'h03: reg_rdata <= r2_q.limit;
        OFS_STATUS: begin
          reg_rdata <= {8'h00, unprog, current_clamp, act_cur, sel_r2,
                        (state_q == ST_TRIP), state_q};
        end
        OFS_RAMP_REF: reg_rdata <= ref_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_profile_decode: assert property (
    (prof_q == 16'h0003) |-> (!r1_cur && r2_cur))
    else $error("profile 3 must give voltage then current");

  chk_dual_ramp_pick: assert property (
    (state_q == ST_IDLE && go) |=> (act_r2_q == $past(dual_ramp_in)))
    else $error("ramp selection not taken from dual-ramp input");

  chk_start_level: assert property (
    (state_q == ST_IDLE && go && !unprog) |=> (ref_q == start_lvl))
    else $error("ramp did not begin at initial level");

  chk_fla_gate: assert property (
    (state_q == ST_IDLE && unprog) |=> (state_q != ST_RAMP))
    else $error("motor started with FULL_LOAD_AMPS unprogrammed");

  chk_clamp_limit: assert property (
    (state_q == ST_RAMP && !trip_now && motor_current >= act.limit) |=> current_clamp)
    else $error("current not clamped during ramp");

  chk_class_switch: assert property (
    (state_q == ST_RAMP) |=> (ol_class == $past(ol_start_q)))
    else $error("running class used before full speed");

  chk_no_trip_off: assert property (
    (mode_q == 16'(OLM_OFF) && state_q != ST_TRIP && state_q != ST_INIT) |=> (state_q != ST_TRIP))
    else $error("thermal trip with overload disabled");

  chk_manual_hold: assert property (
    (state_q == ST_TRIP && mode_q == 16'(OLM_MANUAL) && !reset_key) |=> (state_q == ST_TRIP))
    else $error("manual trip cleared without reset key");

  chk_sf_refuse: assert property (
    (reg_req.wr && wa == OFS_SF && sf_prod > UNIT_MAX_PROD) |=> $stable(sf_q))
    else $error("service factor over-rating accepted");

  chk_ref_bound: assert property (
    (state_q == ST_RAMP) |-> (ref_q <= target))
    else $error("ramp reference passed its target");

endmodule : ssr_ctrl

//--- sim/ssr_motor_model.sv
// Behavioural motor and feedback model facing the ramp controller.
// Assumes drive_en from the controller; the bench picks load current and spin-up time.
`timescale 1ns/1ps
module ssr_motor_model
  import ssr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // From the controller
  input wire logic drive_en,
  // Bench knobs
  input wire logic [15:0] load_cur,
  input wire logic [15:0] spin_cycles,
  // Feedback to the controller
  output logic [15:0] motor_current,
  output logic at_full_speed
);
  logic [15:0] spin_q;

  // Spin-up counter, restarts whenever the drive drops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      spin_q <= 16'h0000;
    end else if (!drive_en) begin
      spin_q <= 16'h0000;
    end else if (spin_q != 16'hFFFF) begin
      spin_q <= spin_q + 16'h0001;
    end
  end

  // A stopped motor draws nothing; FFFF spin time means it never gets to speed
  assign motor_current = drive_en ? load_cur : 16'h0000;
  assign at_full_speed = drive_en && (spin_cycles != 16'hFFFF) && (spin_q >= spin_cycles);
endmodule : ssr_motor_model

//--- sim/test_ssr_ctrl.sv
// Self-checking bench for the soft starter ramp and overload controller.
// Assumes the motor model on the feedback side and a short control tick.
`timescale 1ns/1ps
module test_ssr_ctrl
  import ssr_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  ssr_req_t reg_req = '0;
  logic start_cmd = 1'b0;
  logic two_wire_mode = 1'b1;
  logic reset_key = 1'b0;
  logic dual_ramp_in = 1'b0;
  logic thermal_over = 1'b0;
  logic cool_done = 1'b0;
  logic trip_retained = 1'b0;
  logic [15:0] load_cur = 16'h0064;
  logic [15:0] spin_cycles = 16'hFFFF;
  logic [15:0] reg_rdata, ramp_ref, current_limit, ol_class, motor_current, d, lim, ref_e;
  logic [31:0] current_limit_abs;
  logic drive_en, ramp_is_current, current_clamp, ol_tripped, at_full_speed, cur;
  int error_cnt = 0;
  int n_tests = 0;

  // Address, write data, expected read-back; refused writes leave the old value
  localparam logic [36:0] CFG [30] = '{
    {OFS_FLC, 16'h0031, 16'h0000}, {OFS_FLC, 16'h0064, 16'h0064},
    {OFS_SF, 16'h0082, 16'h0064}, {OFS_FLC, 16'h0055, 16'h0055},
    {OFS_SF, 16'h0073, 16'h0073}, {OFS_FLC, 16'h0056, 16'h0055},
    {OFS_SF, 16'h0083, 16'h0073}, {OFS_PROFILE, 16'h0005, 16'h0001},
    {OFS_PROFILE, 16'h0000, 16'h0001}, {OFS_OL_START, 16'h0004, 16'h000A},
    {OFS_OL_START, 16'h001F, 16'h000A}, {OFS_OL_START, 16'h000F, 16'h000F},
    {OFS_OL_RUN, 16'h0014, 16'h0014}, {OFS_OL_MODE, 16'h0003, 16'h0000},
    {5'h08, 16'h0000, 16'h000A}, {5'h08, 16'h0079, 16'h000A},
    {5'h08, 16'h0001, 16'h0001}, {5'h09, 16'h00C7, 16'h015E},
    {5'h09, 16'h012C, 16'h012C}, {5'h06, 16'h0065, 16'h003C},
    {5'h06, 16'h0014, 16'h0014}, {5'h07, 16'h0259, 16'h00C8},
    {5'h07, 16'h0096, 16'h0096}, {5'h0A, 16'h001E, 16'h001E},
    {5'h0B, 16'h00FA, 16'h00FA}, {5'h0C, 16'h0001, 16'h0001},
    {5'h0D, 16'h0190, 16'h0190}, {5'h0D, 16'h0259, 16'h0190},
    {5'h1E, 16'h1234, 16'h0000}, {5'h1F, 16'h0000, 16'h0000}};

  // Short tick keeps a 1 s ramp at 6400 cycles
  ssr_ctrl #(.TICK_LEN(64)) DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .start_cmd(start_cmd), .two_wire_mode(two_wire_mode),
    .reset_key(reset_key), .dual_ramp_in(dual_ramp_in), .at_full_speed(at_full_speed),
    .motor_current(motor_current), .thermal_over(thermal_over), .cool_done(cool_done),
    .trip_retained(trip_retained), .drive_en(drive_en), .ramp_is_current(ramp_is_current),
    .ramp_ref(ramp_ref), .current_limit(current_limit), .current_limit_abs(current_limit_abs),
    .current_clamp(current_clamp), .ol_class(ol_class), .ol_tripped(ol_tripped));

  ssr_motor_model u_motor (.clk_sys(clk_sys), .reset_n(reset_n), .drive_en(drive_en),
    .load_cur(load_cur), .spin_cycles(spin_cycles), .motor_current(motor_current),
    .at_full_speed(at_full_speed));

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wreg(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask : wreg

  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    reg_req <= '0;
    #1 v = reg_rdata;
  endtask : rreg

  task automatic go(input logic on);
    @(posedge clk_sys);
    start_cmd <= on;
  endtask : go

  task automatic wait_drv(input logic lvl, input int lim_c);
    for (int i = 0; i < lim_c && drive_en !== lvl; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({31'h0, drive_en}, {31'h0, lvl});
  endtask : wait_drv

  // Stop and let the controller settle back to idle
  task automatic stop();
    go(1'b0);
    for (int i = 0; i < 20 && drive_en !== 1'b0; i++) begin
      @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask : stop

  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // Watchdog, well beyond the expected 8k cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({16'h0, current_limit}, 32'h0000015E);
    chk({16'h0, ol_class}, 32'h0000000A);
    rreg(OFS_STATUS, d);
    chk({16'h0, d & 16'h0087}, 32'h00000081);
    go(1'b1);
    repeat (20) @(posedge clk_sys);
    chk({31'h0, drive_en}, 32'h0);
    go(1'b0);
    $display("test reset and unprogrammed start done");
    // Limits and refusals, then the working setup
    foreach (CFG[i]) begin
      wreg(CFG[i][36:32], CFG[i][31:16]);
      rreg(CFG[i][36:32], d);
      chk({16'h0, d}, {16'h0, CFG[i][15:0]});
    end
    $display("test parameter ranges done");
    for (int p = 1; p <= 4; p++) begin
      for (int k = 0; k < 2; k++) begin
        cur = k ? (p == 2 || p == 3) : (p == 2 || p == 4);
        lim = k ? 16'h0190 : 16'h012C;
        ref_e = k ? (cur ? 16'h00FA : 16'h001E) : (cur ? 16'h0096 : 16'h0014);
        wreg(OFS_PROFILE, p[15:0]);
        dual_ramp_in <= k[0];
        go(1'b1);
        wait_drv(1'b1, 10);
        chk({31'h0, ramp_is_current}, {31'h0, cur});
        chk({16'h0, ramp_ref}, {16'h0, ref_e});
        chk({16'h0, current_limit}, {16'h0, lim});
        chk(current_limit_abs, lim * 32'h55);
        stop();
      end
    end
    $display("test profile decode done");
    // Voltage ramp 20 to 100 over 100 ticks, load above the 300 limit
    wreg(OFS_PROFILE, 16'h0001);
    dual_ramp_in <= 1'b0;
    load_cur <= 16'h0190;
    go(1'b1);
    wait_drv(1'b1, 10);
    repeat (4) @(posedge clk_sys);
    #1;
    chk({31'h0, current_clamp}, 32'h1);
    chk({16'h0, ol_class}, 32'h0000000F);
    repeat (3200) @(posedge clk_sys);
    #1;
    chk({31'h0, ramp_ref >= 16'h0039 && ramp_ref <= 16'h003F}, 32'h1);
    chk({16'h0, ol_class}, 32'h0000000F);
    repeat (3600) @(posedge clk_sys);
    #1;
    chk({16'h0, ramp_ref}, 32'h00000064);
    chk({16'h0, ol_class}, 32'h00000014);
    chk({31'h0, current_clamp}, 32'h0);
    stop();
    $display("test ramp timing done");
    spin_cycles <= 16'h012C;
    go(1'b1);
    wait_drv(1'b1, 10);
    repeat (320) @(posedge clk_sys);
    #1;
    chk({16'h0, ol_class}, 32'h00000014);
    $display("test early full speed done");
    // Manual reset needs both cooling and the key
    thermal_over <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({30'h0, ol_tripped, drive_en}, 32'h2);
    go(1'b0);
    thermal_over <= 1'b0;
    reset_key <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({31'h0, ol_tripped}, 32'h1);
    reset_key <= 1'b0;
    cool_done <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({31'h0, ol_tripped}, 32'h1);
    reset_key <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({31'h0, ol_tripped}, 32'h0);
    reset_key <= 1'b0;
    cool_done <= 1'b0;
    // Automatic reset with two-wire start held high
    wreg(OFS_OL_MODE, 16'h0001);
    go(1'b1);
    wait_drv(1'b1, 10);
    thermal_over <= 1'b1;
    repeat (4) @(posedge clk_sys);
    thermal_over <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({31'h0, ol_tripped}, 32'h1);
    cool_done <= 1'b1;
    wait_drv(1'b1, 20);
    cool_done <= 1'b0;
    // Overload disabled
    wreg(OFS_OL_MODE, 16'h0002);
    thermal_over <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    chk({30'h0, ol_tripped, drive_en}, 32'h1);
    thermal_over <= 1'b0;
    stop();
    // Three-wire: automatic reset clears on cooling, restart waits for a fresh press
    wreg(OFS_OL_MODE, 16'h0001);
    two_wire_mode <= 1'b0;
    go(1'b1);
    wait_drv(1'b1, 10);
    thermal_over <= 1'b1;
    repeat (4) @(posedge clk_sys);
    thermal_over <= 1'b0;
    cool_done <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    chk({30'h0, ol_tripped, drive_en}, 32'h0);
    cool_done <= 1'b0;
    two_wire_mode <= 1'b1;
    stop();
    $display("test overload reset modes done");
    // Control power cycle with the trip held in outside memory
    reset_n <= 1'b0;
    trip_retained <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({31'h0, ol_tripped}, 32'h1);
    $display("test power cycle done");
    conclude();
  end
endmodule : test_ssr_ctrl
